// ### rtl/ctor_pkg.sv
// Constants for the processor channel temperature offset register pair.
// Assumes an internal register port (address, write strobe, data) on the monitoring clock.
// Summary of operation
// - Channel two readings get channel two offset
// - Channel three readings get channel three offset
// - Eight-bit offsets, minus 63 to plus 127
// - Lock bit set makes offsets read-only
// - Both offsets reset to zero
package ctor_pkg;
	localparam logic [7:0] CTOR_ADDR_CHAN2_OFFSET = 8'h96;
	localparam logic [7:0] CTOR_ADDR_CHAN3_OFFSET = 8'h97;
	localparam logic [7:0] CTOR_OFFSET_RESET = 8'h00;
	localparam logic signed [9:0] CTOR_OFFSET_MIN = 10'sh3C1; // Minus 63
	localparam logic signed [9:0] CTOR_OFFSET_MAX = 10'sh07F; // Plus 127
	localparam logic signed [9:0] CTOR_TEMP_MIN = 10'sh380; // Minus 128
	localparam logic signed [9:0] CTOR_TEMP_MAX = 10'sh07F; // Plus 127
	localparam int CTOR_NUM_CHAN = 2;
endpackage : ctor_pkg

// ### rtl/ctor_offset_regs.sv
// Offset registers for processor thermal channels two and three, and the adders
// that apply them. Assumes raw readings arrive as signed bytes with a one-cycle
// valid strobe from same-clock logic, and that the lock level comes from config 1.
// The lock is a plain level here; the bit that holds it lives in another block,
// so it needs no synchroniser.
`timescale 1ns/10ps
module ctor_offset_regs (
	input wire logic clk,
	input wire logic rst_n,
	// Register port, on the monitoring clock
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Lock level from configuration register 1
	input wire logic cfg_lock,
	// Raw readings from the channel front ends
	input wire logic [7:0] cpu_thermal_channel_two_raw,
	input wire logic cpu_thermal_channel_two_valid,
	input wire logic [7:0] cpu_thermal_channel_three_raw,
	input wire logic cpu_thermal_channel_three_valid,
	// Corrected readings with their strobes, all from flops
	output logic [7:0] cpu_thermal_channel_two_temp,
	output logic cpu_thermal_channel_two_temp_valid,
	output logic [7:0] cpu_thermal_channel_three_temp,
	output logic cpu_thermal_channel_three_temp_valid
);
	// Offset registers and their next values
	logic [7:0] cpu_chan2_temp_offset;
	logic [7:0] cpu_chan3_temp_offset;
	logic [7:0] next_chan2_offset;
	logic [7:0] next_chan3_offset;
	logic [7:0] next_rdata;
	// Per-channel views so the adder is written once
	logic [7:0] raw [ctor_pkg::CTOR_NUM_CHAN];
	logic [7:0] offs [ctor_pkg::CTOR_NUM_CHAN];
	logic in_valid [ctor_pkg::CTOR_NUM_CHAN];
	logic [7:0] temp [ctor_pkg::CTOR_NUM_CHAN];
	logic [7:0] next_temp [ctor_pkg::CTOR_NUM_CHAN];
	logic temp_valid [ctor_pkg::CTOR_NUM_CHAN];

	// Writes land only while unlocked; a locked write is silently dropped
	always_comb begin
		next_chan2_offset = cpu_chan2_temp_offset;
		next_chan3_offset = cpu_chan3_temp_offset;
		if (reg_wr && !cfg_lock) begin
			// Both addresses are decoded apart so one strobe touches one register
			if (reg_addr == ctor_pkg::CTOR_ADDR_CHAN2_OFFSET) begin
				next_chan2_offset = reg_wdata;
			end
			if (reg_addr == ctor_pkg::CTOR_ADDR_CHAN3_OFFSET) begin
				next_chan3_offset = reg_wdata;
			end
		end
	end

	// Read data is registered; unmapped addresses return zero
	always_comb begin
		// Reads return the stored byte, not the clamped value the adder uses
		case (reg_addr)
			ctor_pkg::CTOR_ADDR_CHAN2_OFFSET: next_rdata = cpu_chan2_temp_offset;
			ctor_pkg::CTOR_ADDR_CHAN3_OFFSET: next_rdata = cpu_chan3_temp_offset;
			default: next_rdata = 8'h00;
		endcase
	end

	// Register state; zero offset means readings pass untouched after reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpu_chan2_temp_offset <= ctor_pkg::CTOR_OFFSET_RESET;
			cpu_chan3_temp_offset <= ctor_pkg::CTOR_OFFSET_RESET;
			reg_rdata <= 8'h00;
		end else begin
			cpu_chan2_temp_offset <= next_chan2_offset;
			cpu_chan3_temp_offset <= next_chan3_offset;
			reg_rdata <= next_rdata;
		end
	end

	// Channel steering so one generate loop serves both channels
	// Channel two sits in slot 0, channel three in slot 1
	assign raw[0] = cpu_thermal_channel_two_raw;
	assign raw[1] = cpu_thermal_channel_three_raw;
	assign in_valid[0] = cpu_thermal_channel_two_valid;
	assign in_valid[1] = cpu_thermal_channel_three_valid;
	assign offs[0] = cpu_chan2_temp_offset;
	assign offs[1] = cpu_chan3_temp_offset;

	// Signed add with saturation so a large offset cannot wrap a hot reading cold
	for (genvar g = 0; g < ctor_pkg::CTOR_NUM_CHAN; g++) begin : g_chan
		logic signed [9:0] sum;
		logic signed [9:0] offs_c;
		logic [7:0] sat;
		// Offset widened with its sign so negative bytes subtract
		always_comb begin
			offs_c = 10'(signed'(offs[g]));
			// Bytes below the legal minimum are clamped to it; the register keeps the byte as written
			if (offs_c < ctor_pkg::CTOR_OFFSET_MIN) begin
				offs_c = ctor_pkg::CTOR_OFFSET_MIN;
			end
			// Ten bits hold every raw plus offset sum, so the add itself never overflows
			sum = 10'(signed'(raw[g])) + offs_c;
			if (sum > ctor_pkg::CTOR_TEMP_MAX) begin
				sat = 8'h7F;
			end else if (sum < ctor_pkg::CTOR_TEMP_MIN) begin
				sat = 8'h80;
			end else begin
				sat = sum[7:0];
			end
			// A corrected reading stands until the next raw strobe replaces it
			next_temp[g] = temp[g];
			if (in_valid[g]) begin
				next_temp[g] = sat;
			end
		end
		// Result and its strobe, one cycle behind the raw strobe
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				temp[g] <= 8'h00;
				temp_valid[g] <= 1'b0;
			end else begin
				temp[g] <= next_temp[g];
				temp_valid[g] <= in_valid[g];
			end
		end
	end

	assign cpu_thermal_channel_two_temp = temp[0];
	assign cpu_thermal_channel_two_temp_valid = temp_valid[0];
	assign cpu_thermal_channel_three_temp = temp[1];
	assign cpu_thermal_channel_three_temp_valid = temp_valid[1];

	// Checks on the offset registers and the applied readings.
	// Register side: lock, write, read-back and reset behaviour
	a_lock_holds2: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_lock |=> cpu_chan2_temp_offset == $past(cpu_chan2_temp_offset))
		else $error("channel two offset changed while locked");
	a_lock_holds3: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_lock |=> cpu_chan3_temp_offset == $past(cpu_chan3_temp_offset))
		else $error("channel three offset changed while locked");
	a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && !cfg_lock && reg_addr == ctor_pkg::CTOR_ADDR_CHAN2_OFFSET)
		|=> cpu_chan2_temp_offset == $past(reg_wdata))
		else $error("unlocked write to channel two offset lost");
	a_write_lands3: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && !cfg_lock && reg_addr == ctor_pkg::CTOR_ADDR_CHAN3_OFFSET)
		|=> cpu_chan3_temp_offset == $past(reg_wdata))
		else $error("unlocked write to channel three offset lost");
	a_read_back2: assert property (@(posedge clk) disable iff (!rst_n)
		reg_addr == ctor_pkg::CTOR_ADDR_CHAN2_OFFSET |=> reg_rdata == $past(cpu_chan2_temp_offset))
		else $error("channel two offset read back wrong");
	a_read_back3: assert property (@(posedge clk) disable iff (!rst_n)
		reg_addr == ctor_pkg::CTOR_ADDR_CHAN3_OFFSET |=> reg_rdata == $past(cpu_chan3_temp_offset))
		else $error("channel three offset read back wrong");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_addr != ctor_pkg::CTOR_ADDR_CHAN2_OFFSET && reg_addr != ctor_pkg::CTOR_ADDR_CHAN3_OFFSET)
		|=> reg_rdata == 8'h00)
		else $error("unmapped address read not zero");
	a_reset_zero: assert property (@(posedge clk)
		!rst_n |=> cpu_chan2_temp_offset == 8'h00 && cpu_chan3_temp_offset == 8'h00)
		else $error("offsets not zero after reset");
	a_reset_outputs: assert property (@(posedge clk)
		!rst_n |=> reg_rdata == 8'h00 && !cpu_thermal_channel_two_temp_valid
		&& !cpu_thermal_channel_three_temp_valid)
		else $error("outputs not cleared by reset");

	// Reading side: offsets applied, signed, saturated, strobes one cycle late
	a_zero_passes: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_two_valid && cpu_chan2_temp_offset == 8'h00)
		|=> cpu_thermal_channel_two_temp == $past(cpu_thermal_channel_two_raw))
		else $error("channel two reading altered with zero offset");
	a_chan3_apply: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_three_valid && cpu_chan3_temp_offset == 8'h05
		&& cpu_thermal_channel_three_raw == 8'h32)
		|=> cpu_thermal_channel_three_temp == 8'h37)
		else $error("channel three offset not applied");
	a_signed_add: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_two_valid && cpu_chan2_temp_offset == 8'hF6
		&& cpu_thermal_channel_two_raw == 8'h32)
		|=> cpu_thermal_channel_two_temp == 8'h28)
		else $error("negative offset not subtracted");
	a_clamp_floor: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_three_valid && cpu_chan3_temp_offset == 8'h80
		&& cpu_thermal_channel_three_raw == 8'h00)
		|=> cpu_thermal_channel_three_temp == 8'hC1)
		else $error("offset below minimum not clamped");
	a_no_wrap_high: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_three_valid && !cpu_thermal_channel_three_raw[7] && !cpu_chan3_temp_offset[7])
		|=> !cpu_thermal_channel_three_temp[7])
		else $error("hot reading wrapped negative");
	a_no_wrap_low: assert property (@(posedge clk) disable iff (!rst_n)
		(cpu_thermal_channel_two_valid && cpu_thermal_channel_two_raw[7] && cpu_chan2_temp_offset[7])
		|=> cpu_thermal_channel_two_temp[7])
		else $error("cold reading wrapped positive");
	a_valid_follows: assert property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_three_valid |=> cpu_thermal_channel_three_temp_valid)
		else $error("channel three result strobe missing");
	a_valid_follows2: assert property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_two_valid |=> cpu_thermal_channel_two_temp_valid)
		else $error("channel two result strobe missing");
	a_strobe_drops2: assert property (@(posedge clk) disable iff (!rst_n)
		!cpu_thermal_channel_two_valid |=> !cpu_thermal_channel_two_temp_valid)
		else $error("channel two result strobe without reading");
	a_strobe_drops3: assert property (@(posedge clk) disable iff (!rst_n)
		!cpu_thermal_channel_three_valid |=> !cpu_thermal_channel_three_temp_valid)
		else $error("channel three result strobe without reading");
	a_temp_holds2: assert property (@(posedge clk) disable iff (!rst_n)
		!cpu_thermal_channel_two_valid |=> $stable(cpu_thermal_channel_two_temp))
		else $error("channel two result changed without reading");
	a_temp_holds3: assert property (@(posedge clk) disable iff (!rst_n)
		!cpu_thermal_channel_three_valid |=> $stable(cpu_thermal_channel_three_temp))
		else $error("channel three result changed without reading");

	// Scenarios worth seeing at least once
	c_locked_write: cover property (@(posedge clk) disable iff (!rst_n)
		reg_wr && cfg_lock && reg_addr == ctor_pkg::CTOR_ADDR_CHAN3_OFFSET);
	c_neg_offset: cover property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_two_valid && cpu_chan2_temp_offset[7]);
	c_saturate: cover property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_three_temp_valid && cpu_thermal_channel_three_temp == 8'h7F);
	c_floor_sat: cover property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_two_temp_valid && cpu_thermal_channel_two_temp == 8'h80);
	c_clamp: cover property (@(posedge clk) disable iff (!rst_n)
		cpu_thermal_channel_three_valid && cpu_chan3_temp_offset == 8'h80);
endmodule : ctor_offset_regs

// ### sim/tb_ctor_offset_regs.sv
// Self-checking bench for the channel two and three offset registers and their adders.
// Assumes reads and corrected readings come back exactly one cycle after the request.
`timescale 1ns/10ps
module tb_ctor_offset_regs;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic cfg_lock = 1'b0;
	logic [7:0] raw2 = 8'h00;
	logic [7:0] raw3 = 8'h00;
	logic v2 = 1'b0;
	logic v3 = 1'b0;
	logic [7:0] rdata, t2, t3;
	logic tv2, tv3;
	int n_mismatch = 0;
	int n_tests = 0;
	// Clock, 5 ns period
	always #2.5 clk = ~clk;
	ctor_offset_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(rdata), .cfg_lock(cfg_lock),
		.cpu_thermal_channel_two_raw(raw2), .cpu_thermal_channel_two_valid(v2),
		.cpu_thermal_channel_three_raw(raw3), .cpu_thermal_channel_three_valid(v3),
		.cpu_thermal_channel_two_temp(t2), .cpu_thermal_channel_two_temp_valid(tv2),
		.cpu_thermal_channel_three_temp(t3), .cpu_thermal_channel_three_temp_valid(tv3));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Inputs change on the falling edge only, so the rising edge never races them
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		chk(rdata, e);
	endtask : rd
	// One-cycle valid; the corrected value follows one edge later, then the strobe drops and the value stands
	task meas(input logic two, input logic [7:0] r, input logic [7:0] e);
		@(negedge clk);
		if (two) begin v2 = 1'b1; raw2 = r; end else begin v3 = 1'b1; raw3 = r; end
		@(negedge clk);
		v2 = 1'b0; v3 = 1'b0;
		chk({7'h00, two ? tv2 : tv3}, 8'h01);
		chk(two ? t2 : t3, e);
		@(negedge clk);
		chk({7'h00, two ? tv2 : tv3}, 8'h00);
		chk(two ? t2 : t3, e);
	endtask : meas
	task t_reset;
		rd(8'h96, 8'h00);
		rd(8'h97, 8'h00);
		meas(1'b1, 8'h32, 8'h32);
		meas(1'b0, 8'hF0, 8'hF0);
	endtask : t_reset
	task t_write;
		wr(8'h96, 8'hF6);
		wr(8'h97, 8'h80);
		rd(8'h96, 8'hF6);
		rd(8'h97, 8'h80);
		rd(8'h41, 8'h00);
		meas(1'b1, 8'h32, 8'h28);
		meas(1'b1, 8'h80, 8'h80);
		meas(1'b0, 8'h00, 8'hC1);
		wr(8'h97, 8'h05);
		meas(1'b0, 8'h32, 8'h37);
		wr(8'h97, 8'h7F);
		meas(1'b0, 8'h10, 8'h7F);
		meas(1'b0, 8'h81, 8'h00);
	endtask : t_write
	// Lock mid-run: both writes must bounce off, the channel two offset keeps acting
	task t_lock;
		@(negedge clk);
		cfg_lock = 1'b1;
		wr(8'h96, 8'h11);
		wr(8'h97, 8'h22);
		rd(8'h96, 8'hF6);
		rd(8'h97, 8'h7F);
		meas(1'b1, 8'h32, 8'h28);
	endtask : t_lock
	// Reset in mid-run with the lock dropped: everything returns to zero, writes land again
	task t_rereset;
		@(negedge clk);
		rst_n = 1'b0;
		cfg_lock = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		chk({6'h00, tv2, tv3}, 8'h00);
		chk(t2, 8'h00);
		chk(t3, 8'h00);
		rd(8'h96, 8'h00);
		rd(8'h97, 8'h00);
		meas(1'b1, 8'h32, 8'h32);
		wr(8'h96, 8'h05);
		rd(8'h96, 8'h05);
	endtask : t_rereset
	task finish_test;
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	// Watchdog against a hung run
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
	// Main sequence after 16 cycles of reset
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_write();
		t_lock();
		t_rereset();
		finish_test();
	end
endmodule : tb_ctor_offset_regs
